// >>> hdl/iicr_pkg.sv
// Shared constants and types for the infrared, interrupt and DMA configuration registers
package iicr_pkg;

    // Configuration register indices
    localparam logic [7:0] IDX_IRQ_ROUTING = 8'h29;
    localparam logic [7:0] IDX_RSVD_A = 8'h2A;
    localparam logic [7:0] IDX_HSIR_BASE = 8'h2B;
    localparam logic [7:0] IDX_DMA_SELECT = 8'h2C;
    localparam logic [7:0] IDX_HD_TIMEOUT = 8'h2D;
    localparam logic [7:0] IDX_RSVD_E = 8'h2E;
    localparam logic [7:0] IDX_RSVD_F = 8'h2F;

    // Field positions
    localparam int ROUTE_LSB = 0;
    localparam int ROUTE_W = 4;
    localparam int ROLE_LSB = 4;
    localparam int ROLE_W = 2;
    localparam int DMA_LSB = 0;
    localparam int DMA_W = 4;
    localparam int BASE_EN_LSB = 5;
    localparam int ADDR_W = 11;
    localparam int ADDR_IGNORE_W = 3;

    // Reset values
    localparam logic [7:0] RST_IRQ_ROUTING = 8'h00;
    localparam logic [7:0] RST_HSIR_BASE = 8'h00;
    localparam logic [7:0] RST_DMA_SELECT = 8'h00;
    localparam logic [7:0] RST_HD_TIMEOUT = 8'h03;
    localparam logic [7:0] RST_RSVD = 8'h00;

    // Interrupt routing codes
    localparam logic [3:0] IRQ_CODE_H = 4'h8;
    localparam logic [3:0] IRQ_CODE_LAST_AF = 4'h6;
    localparam int IRQ_LINES = 8;
    localparam int IRQ_H_BIT = 7;
    localparam int DMA_LINES = 3;

    // Blanking timing
    localparam int CLK_MHZ = 10;
    localparam int STEP_US = 100;
    localparam int MAX_MS = 10;
    localparam int STEP_CYCLES = STEP_US * CLK_MHZ;
    localparam logic [7:0] MAX_STEPS = 8'((MAX_MS * 1000) / STEP_US);

    typedef enum logic [1:0] {
        ROLE_IRQ = 2'h0,
        ROLE_IR = 2'h1,
        ROLE_ALT_RX = 2'h2,
        ROLE_RSVD = 2'h3
    } iicr_role_t;

    typedef enum logic [2:0] {
        BLK_IDLE = 3'b001,
        BLK_TX = 3'b010,
        BLK_HOLD = 3'b100
    } iicr_blank_t;

    // Configuration port request
    typedef struct packed {
        logic mode;
        logic wr;
        logic rd;
        logic [7:0] index;
        logic [7:0] wdata;
    } iicr_cfg_req_t;

endpackage

// >>> hdl/iicr_config_regs.sv
// Interrupt routing, infrared pin role, fast infrared decode, DMA select and blanking timer
// Notes on behaviour
// - Registers accessible only in configuration mode with the index holding their number.
// - Routing register low four bits pick the host line for the interrupt pin.
// - Codes: 0 none, 1-6 lines A-F, 7 reserved, 8 line H.
// - Host interrupt lines not selected by routing are released, not driven.
// - Bits five and four choose pin role: interrupt, infrared, alternate receive, reserved.
// - Routing register top two bits read as zero.
// - Base register holds address bits ten to three, eight-byte aligned.
// - Base top three bits all zero disables the fast infrared decode.
// - Select needs device select low and address bits ten to three matching.
// - When the fast infrared block is absent, base discards writes, reads zero.
// - DMA register low bits: 0 none, 1 channel A, 2 B, 3 C.
// - DMA register upper four bits ignore writes and read zero.
// - DMA request lines not selected are released, not driven.
// - Receive blanked during transmit plus timeout times 100 microseconds afterwards.
// - Timeout register resets to three.
// - Reserved registers in this range reset to zero and read zero.
`timescale 1ns/1ps

module iicr_config_regs #(
    parameter bit HSIR_PRESENT = 1'b1
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // Configuration index port
    input wire iicr_pkg::iicr_cfg_req_t i_cfg,
    output logic [7:0] o_cfg_rdata,
    // Host address decode
    input wire logic i_device_select_n,
    input wire logic [iicr_pkg::ADDR_W-1:0] i_host_addr,
    output logic o_hsir_select,
    // External interrupt pin and its roles
    input wire logic i_external_interrupt_input,
    output logic o_infrared_mode,
    output logic o_alternate_infrared_select,
    output logic o_alternate_infrared_receive,
    // Host interrupt lines
    output logic [iicr_pkg::IRQ_LINES-1:0] o_irq_line,
    output logic [iicr_pkg::IRQ_LINES-1:0] o_irq_oe,
    // DMA request lines
    input wire logic i_hsir_dma_req,
    output logic [iicr_pkg::DMA_LINES-1:0] o_dma_req,
    output logic [iicr_pkg::DMA_LINES-1:0] o_dma_oe,
    // Half-duplex blanking
    input wire logic i_ir_tx_active,
    output logic o_rx_blank
);
    import iicr_pkg::*;

    localparam int PRE_W = $clog2(STEP_CYCLES);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(STEP_CYCLES - 1);
    // Select widths sized to the vectors so decode indices never overrun
    localparam int IRQ_SEL_W = $clog2(IRQ_LINES);
    localparam int DMA_SEL_W = $clog2(DMA_LINES);

    logic [ROUTE_W-1:0] route_reg;
    iicr_role_t role_reg;
    logic [7:0] base_reg;
    logic [DMA_W-1:0] dma_reg;
    logic [7:0] timeout_reg;
    logic ext_s1_reg;
    logic ext_s2_reg;
    logic ext_s3_reg;
    logic ext_level_reg;
    iicr_blank_t blank_reg;
    iicr_blank_t blank_next;
    logic [7:0] steps_reg;
    logic [PRE_W-1:0] pre_reg;
    logic step_tick;
    logic [7:0] steps_limit;
    logic [IRQ_LINES-1:0] irq_sel;
    logic [DMA_LINES-1:0] dma_sel;
    logic [7:0] rd_value;

    function automatic logic wr_hit(input iicr_cfg_req_t req, input logic [7:0] idx);
        wr_hit = req.mode && req.wr && (req.index == idx);
    endfunction

    // Reserved code and codes above line H leave every line released
    function automatic logic [IRQ_LINES-1:0] irq_decode(input logic [ROUTE_W-1:0] code);
        logic [IRQ_LINES-1:0] hot;
        hot = '0;
        if (code != '0 && code <= IRQ_CODE_LAST_AF) begin
            hot[IRQ_SEL_W'(code - 4'h1)] = 1'b1;
        end else if (code == IRQ_CODE_H) begin
            hot[IRQ_H_BIT] = 1'b1;
        end
        irq_decode = hot;
    endfunction

    // Routing register
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            route_reg <= RST_IRQ_ROUTING[ROUTE_LSB +: ROUTE_W];
            role_reg <= iicr_role_t'(RST_IRQ_ROUTING[ROLE_LSB +: ROLE_W]);
        end else if (wr_hit(i_cfg, IDX_IRQ_ROUTING)) begin
            route_reg <= i_cfg.wdata[ROUTE_LSB +: ROUTE_W];
            role_reg <= iicr_role_t'(i_cfg.wdata[ROLE_LSB +: ROLE_W]);
        end
    end

    // Fast infrared base
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            base_reg <= RST_HSIR_BASE;
        end else if (HSIR_PRESENT && wr_hit(i_cfg, IDX_HSIR_BASE)) begin
            base_reg <= i_cfg.wdata;
        end
    end

    // DMA select
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            dma_reg <= RST_DMA_SELECT[DMA_LSB +: DMA_W];
        end else if (wr_hit(i_cfg, IDX_DMA_SELECT)) begin
            dma_reg <= i_cfg.wdata[DMA_LSB +: DMA_W];
        end
    end

    // Half-duplex timeout
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            timeout_reg <= RST_HD_TIMEOUT;
        end else if (wr_hit(i_cfg, IDX_HD_TIMEOUT)) begin
            timeout_reg <= i_cfg.wdata;
        end
    end

    // Read mux; reserved bits and reserved indices give zero
    always_comb begin
        rd_value = 8'h00;
        unique case (i_cfg.index)
            IDX_IRQ_ROUTING: begin
                rd_value = {2'b00, role_reg, route_reg};
            end
            IDX_HSIR_BASE: begin
                rd_value = HSIR_PRESENT ? base_reg : 8'h00;
            end
            IDX_DMA_SELECT: begin
                rd_value = {4'h0, dma_reg};
            end
            IDX_HD_TIMEOUT: begin
                rd_value = timeout_reg;
            end
            IDX_RSVD_A, IDX_RSVD_E, IDX_RSVD_F: begin
                rd_value = RST_RSVD;
            end
            default: begin
                rd_value = 8'h00;
            end
        endcase
    end

    // Read data holds until the next read strobe
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_cfg_rdata <= 8'h00;
        end else if (i_cfg.rd) begin
            o_cfg_rdata <= i_cfg.mode ? rd_value : 8'h00;
        end
    end

    // Pin synchroniser; stage one feeds only stage two
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
            ext_s3_reg <= 1'b0;
            ext_level_reg <= 1'b0;
        end else begin
            ext_s1_reg <= i_external_interrupt_input;
            ext_s2_reg <= ext_s1_reg;
            ext_s3_reg <= ext_s2_reg;
            if (ext_s2_reg == ext_s3_reg) begin
                ext_level_reg <= ext_s3_reg;
            end
        end
    end

    // Interrupt routing is only live in plain interrupt role
    always_comb begin
        irq_sel = '0;
        if (role_reg == ROLE_IRQ) begin
            irq_sel = irq_decode(route_reg);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_irq_line <= '0;
            o_irq_oe <= '0;
        end else begin
            o_irq_oe <= irq_sel;
            o_irq_line <= irq_sel & {IRQ_LINES{ext_level_reg}};
        end
    end

    // Pin role outputs; reserved role drives nothing
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_infrared_mode <= 1'b0;
            o_alternate_infrared_select <= 1'b0;
            o_alternate_infrared_receive <= 1'b0;
        end else begin
            o_infrared_mode <= (role_reg == ROLE_IR) || (role_reg == ROLE_ALT_RX);
            o_alternate_infrared_select <= (role_reg == ROLE_ALT_RX);
            o_alternate_infrared_receive <= (role_reg == ROLE_ALT_RX) && ext_level_reg;
        end
    end

    // Fast infrared address decode
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_hsir_select <= 1'b0;
        end else begin
            o_hsir_select <= HSIR_PRESENT
                && (base_reg[7:BASE_EN_LSB] != '0)
                && !i_device_select_n
                && (i_host_addr[ADDR_W-1:ADDR_IGNORE_W] == base_reg);
        end
    end

    // DMA routing
    always_comb begin
        dma_sel = '0;
        if (dma_reg != '0 && dma_reg <= 4'(DMA_LINES)) begin
            dma_sel[DMA_SEL_W'(dma_reg - 4'h1)] = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_dma_req <= '0;
            o_dma_oe <= '0;
        end else begin
            o_dma_oe <= dma_sel;
            o_dma_req <= dma_sel & {DMA_LINES{i_hsir_dma_req}};
        end
    end

    // Blanking timer
    // Clamp caps undefined long timeouts at ten milliseconds
    assign steps_limit = (timeout_reg > MAX_STEPS) ? MAX_STEPS : timeout_reg;
    assign step_tick = (pre_reg == PRE_LAST);

    always_comb begin
        blank_next = blank_reg;
        unique case (blank_reg)
            BLK_IDLE: begin
                if (i_ir_tx_active) begin
                    blank_next = BLK_TX;
                end
            end
            BLK_TX: begin
                if (!i_ir_tx_active) begin
                    blank_next = (steps_limit == 8'h00) ? BLK_IDLE : BLK_HOLD;
                end
            end
            BLK_HOLD: begin
                if (i_ir_tx_active) begin
                    blank_next = BLK_TX;
                end else if (step_tick && steps_reg == 8'h01) begin
                    blank_next = BLK_IDLE;
                end
            end
            default: begin
                blank_next = BLK_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            blank_reg <= BLK_IDLE;
            o_rx_blank <= 1'b0;
        end else begin
            blank_reg <= blank_next;
            // Follows the next state so blanking starts on the first transmit edge
            o_rx_blank <= (blank_next != BLK_IDLE);
        end
    end

    // Step divider restarts when the hold begins
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            pre_reg <= '0;
            steps_reg <= 8'h00;
        end else if (blank_reg != BLK_HOLD) begin
            pre_reg <= '0;
            steps_reg <= steps_limit;
        end else if (step_tick) begin
            pre_reg <= '0;
            steps_reg <= steps_reg - 8'h01;
        end else begin
            pre_reg <= pre_reg + PRE_W'(1);
        end
    end

endmodule

// >>> sim/iicr_monitor.sv
// Port-level assertions for the configuration register block
`timescale 1ns/1ps
module iicr_monitor (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // Watched ports
    input wire iicr_pkg::iicr_cfg_req_t i_cfg,
    input wire logic [7:0] o_cfg_rdata,
    input wire logic i_device_select_n,
    input wire logic [iicr_pkg::ADDR_W-1:0] i_host_addr,
    input wire logic o_hsir_select,
    input wire logic o_infrared_mode,
    input wire logic [iicr_pkg::IRQ_LINES-1:0] o_irq_line,
    input wire logic [iicr_pkg::IRQ_LINES-1:0] o_irq_oe,
    input wire logic [iicr_pkg::DMA_LINES-1:0] o_dma_req,
    input wire logic [iicr_pkg::DMA_LINES-1:0] o_dma_oe,
    input wire logic i_ir_tx_active,
    input wire logic o_rx_blank
);
    import iicr_pkg::*;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    logic rd_on;
    logic rd_rsvd;
    assign rd_on = i_cfg.rd && i_cfg.mode;
    assign rd_rsvd = rd_on && (i_cfg.index inside {IDX_RSVD_A, IDX_RSVD_E, IDX_RSVD_F});
    chk_read_closed: assert property (i_cfg.rd && !i_cfg.mode |=> o_cfg_rdata == 8'h00)
        else $error("read outside config mode gave data");
    chk_rsvd_reads: assert property (rd_rsvd |=> o_cfg_rdata == 8'h00)
        else $error("reserved register read nonzero");
    chk_route_top: assert property (rd_on && i_cfg.index == IDX_IRQ_ROUTING |=> o_cfg_rdata[7:6] == 2'h0)
        else $error("routing top bits nonzero");
    chk_irq_release: assert property ($onehot0(o_irq_oe) && !o_irq_oe[6] && (o_irq_line & ~o_irq_oe) == 8'h00)
        else $error("unselected interrupt line driven");
    chk_dma_release: assert property ($onehot0(o_dma_oe) && (o_dma_req & ~o_dma_oe) == 3'h0)
        else $error("unselected dma line driven");
    chk_select_cause: assert property (o_hsir_select |-> $past(!i_device_select_n && i_host_addr[10:8] != 3'h0))
        else $error("decode without cause");
    chk_ir_role: assert property (o_infrared_mode |-> o_irq_oe == 8'h00)
        else $error("interrupt routed in infrared role");
    chk_blank_tx: assert property (i_ir_tx_active ##1 i_ir_tx_active |=> o_rx_blank)
        else $error("receive not blanked in transmit");
endmodule

bind iicr_config_regs iicr_monitor mon_i (
    .i_sys_clk, .i_nrst, .i_cfg, .o_cfg_rdata, .i_device_select_n, .i_host_addr, .o_hsir_select,
    .o_infrared_mode, .o_irq_line, .o_irq_oe, .o_dma_req, .o_dma_oe, .i_ir_tx_active, .o_rx_blank
);

// >>> sim/iicr_host_model.sv
// Host model driving the configuration index port
`timescale 1ns/1ps
module iicr_host_model (
    // Clock
    input wire logic i_sys_clk,
    // Configuration port
    output iicr_pkg::iicr_cfg_req_t o_cfg,
    input wire logic [7:0] i_cfg_rdata
);
    import iicr_pkg::*;
    initial o_cfg = '{mode: 1'b0, wr: 1'b0, rd: 1'b0, index: 8'h00, wdata: 8'h00};
    task automatic access(input logic m, input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(negedge i_sys_clk);
        o_cfg = '{mode: m, wr: w, rd: !w, index: idx, wdata: d};
        @(negedge i_sys_clk);
        // Inverted leftovers so a stale index never passes
        o_cfg = '{mode: m, wr: 1'b0, rd: 1'b0, index: ~idx, wdata: ~d};
    endtask
    task automatic read(input logic m, input logic [7:0] idx, output logic [7:0] v);
        access(m, 1'b0, idx, 8'h00);
        @(negedge i_sys_clk);
        v = i_cfg_rdata;
    endtask
endmodule

// >>> sim/tb_top.sv
// Self-checking bench for the configuration register block
`timescale 1ns/1ps
module tb_top;
    import iicr_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_device_select_n = 1'b1;
    logic i_external_interrupt_input = 1'b0;
    logic i_hsir_dma_req = 1'b0;
    logic i_ir_tx_active = 1'b0;
    logic [ADDR_W-1:0] i_host_addr = '0;
    iicr_cfg_req_t i_cfg;
    logic [7:0] o_cfg_rdata;
    logic o_hsir_select, o_infrared_mode, o_alternate_infrared_select, o_alternate_infrared_receive, o_rx_blank;
    logic [IRQ_LINES-1:0] o_irq_line, o_irq_oe;
    logic [DMA_LINES-1:0] o_dma_req, o_dma_oe;
    int num_errors = 0;
    int compares = 0;
    int mdl [int];
    logic [7:0] bases [5] = '{8'h00, 8'h1F, 8'h20, 8'hE0, 8'hFF};

    always #50 i_sys_clk = ~i_sys_clk;

    iicr_host_model iicr_host_model_i (.i_sys_clk, .o_cfg(i_cfg), .i_cfg_rdata(o_cfg_rdata));
    iicr_config_regs iicr_config_regs_i (
        .i_sys_clk, .i_nrst, .i_cfg, .o_cfg_rdata, .i_device_select_n, .i_host_addr, .o_hsir_select,
        .i_external_interrupt_input, .o_infrared_mode, .o_alternate_infrared_select,
        .o_alternate_infrared_receive, .o_irq_line, .o_irq_oe, .i_hsir_dma_req, .o_dma_req,
        .o_dma_oe, .i_ir_tx_active, .o_rx_blank
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Model keeps only bits that read back
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        iicr_host_model_i.access(1'b1, 1'b1, idx, d);
        case (idx)
            IDX_IRQ_ROUTING: mdl[idx] = d & 8'h3F;
            IDX_HSIR_BASE, IDX_HD_TIMEOUT: mdl[idx] = d;
            IDX_DMA_SELECT: mdl[idx] = d & 8'h0F;
            default: ;
        endcase
        repeat (3) @(negedge i_sys_clk);
    endtask
    task automatic rd_chk(input logic [7:0] idx);
        logic [7:0] v;
        iicr_host_model_i.read(1'b1, idx, v);
        check(v, mdl.exists(idx) ? 8'(mdl[idx]) : 8'h00);
    endtask

    initial begin
        repeat (20000) @(posedge i_sys_clk);
        num_errors++;
        print_verdict();
    end

    initial begin
        int k;
        logic [7:0] d;
        logic [7:0] e;
        logic [7:0] v;
        void'($urandom(32'hF471));
        mdl = '{'h29: 0, 'h2A: 0, 'h2B: 0, 'h2C: 0, 'h2D: 3, 'h2E: 0, 'h2F: 0};
        repeat (5) @(negedge i_sys_clk);
        i_nrst = 1'b1;
        for (k = 'h28; k <= 'h30; k++) rd_chk(8'(k));
        // Leaves 03 in the read data, so a closed read must clear it
        rd_chk(IDX_HD_TIMEOUT);
        iicr_host_model_i.access(1'b0, 1'b1, IDX_HD_TIMEOUT, 8'hAA);
        iicr_host_model_i.read(1'b0, IDX_HD_TIMEOUT, v);
        check(v, 8'h00);
        rd_chk(IDX_HD_TIMEOUT);
        repeat (40) begin
            k = $urandom_range('h2F, 'h29);
            d = 8'($urandom);
            if (k == 'h29 && d[5:4] != 2'h0) d[3:0] = 4'h0;
            wr(8'(k), d);
            rd_chk(8'(k));
        end
        for (k = 0; k < 16; k++) begin
            i_external_interrupt_input = 1'($urandom);
            wr(IDX_IRQ_ROUTING, 8'(k));
            repeat (3) @(negedge i_sys_clk);
            e = (k >= 1 && k <= 6) ? 8'(1 << (k - 1)) : (k == 8 ? 8'h80 : 8'h00);
            check(o_irq_oe, e);
            check(o_irq_line, i_external_interrupt_input ? e : 8'h00);
        end
        for (k = 0; k < 4; k++) begin
            i_external_interrupt_input = 1'($urandom);
            wr(IDX_IRQ_ROUTING, 8'h00);
            wr(IDX_IRQ_ROUTING, 8'(k << 4));
            repeat (3) @(negedge i_sys_clk);
            e = {5'h00, k == 2 && i_external_interrupt_input, k == 2, k == 1 || k == 2};
            v = {5'h00, o_alternate_infrared_receive, o_alternate_infrared_select, o_infrared_mode};
            check(v, e);
        end
        for (k = 0; k < 16; k++) begin
            i_hsir_dma_req = 1'($urandom);
            wr(IDX_DMA_SELECT, 8'(k));
            e = (k >= 1 && k <= 3) ? 8'(1 << (k - 1)) : 8'h00;
            check({5'h00, o_dma_oe}, e);
            check({5'h00, o_dma_req}, i_hsir_dma_req ? e : 8'h00);
        end
        i_device_select_n = 1'b0;
        for (k = 0; k < 5; k++) begin
            wr(IDX_HSIR_BASE, bases[k]);
            i_host_addr = {bases[k], 3'($urandom)};
            @(negedge i_sys_clk);
            check({7'h00, o_hsir_select}, {7'h00, bases[k][7:5] != 3'h0});
            i_host_addr[3] = ~i_host_addr[3];
            @(negedge i_sys_clk);
            check({7'h00, o_hsir_select}, 8'h00);
        end
        i_host_addr[3] = ~i_host_addr[3];
        i_device_select_n = 1'b1;
        @(negedge i_sys_clk);
        check({7'h00, o_hsir_select}, 8'h00);
        for (k = 0; k < 2; k++) begin
            wr(IDX_HD_TIMEOUT, 8'(k * 2));
            i_ir_tx_active = 1'b1;
            repeat (3) @(negedge i_sys_clk);
            check({7'h00, o_rx_blank}, 8'h01);
            i_ir_tx_active = 1'b0;
            // Hold runs for exactly the programmed steps of STEP_CYCLES each
            repeat (k == 0 ? 3 : 2 * STEP_CYCLES) @(negedge i_sys_clk);
            check({7'h00, o_rx_blank}, 8'(k));
            repeat (k) @(negedge i_sys_clk);
            check({7'h00, o_rx_blank}, 8'h00);
        end
        print_verdict();
    end
endmodule
